//--- bench/lnbsci_master.sv
// Behavioural bus master that sends command frames byte by byte.
`timescale 1ns/1ps
module lnbsci_master
   import lnbsci_pkg::*;
#(
   parameter int UPDATE_GAP = 40
)
(
   input wire logic core_clk_i,
   output lnbsci_byte_t byte_o,
   output logic valid_o,
   output logic end_o
);
   // The bus starts idle.
   initial {byte_o, valid_o, end_o} = 10'h000;
   // Sends framing, address, command and n data bytes, then the end pulse.
   task automatic send(input lnbsci_byte_t a, c, d0, d1, input int n);
      lnbsci_byte_t b [5];
      b = '{8'he0, a, c, d0, d1};
      for (int i = 0; i < n + 3; i++) begin
         @(posedge core_clk_i);
         byte_o <= b[i];
         valid_o <= 1'b1;
         @(posedge core_clk_i);
         byte_o <= ~b[i]; // Released data shows the inverse, never a stale value.
         valid_o <= 1'b0;
      end
      @(posedge core_clk_i);
      end_o <= 1'b1;
      @(posedge core_clk_i);
      end_o <= 1'b0;
      if (c == 8'h0f) repeat (UPDATE_GAP) @(posedge core_clk_i);
   endtask
endmodule

//--- bench/lnbsci_top_chk.sv
// Port-level assertions for the command interpreter.
`timescale 1ns/1ps
module lnbsci_top_chk
   import lnbsci_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire lnbsci_byte_t bus_receive_byte_i,
   input wire logic bus_receive_valid_i,
   input wire logic bus_receive_end_i,
   input wire lnbsci_byte_t bus_transmit_byte_o,
   input wire logic bus_transmit_valid_o,
   input wire logic bus_transmit_last_o,
   input wire logic standby_output_o,
   input wire logic legacy_mode_o
);
   logic [2:0] cnt_r;
   logic [23:0] head_r;
   logic fok;
   // Keeps the first three bytes of the frame being received and counts its bytes.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 3'h0;
         head_r <= 24'h0;
      end else if (bus_receive_end_i) begin
         cnt_r <= 3'h0;
      end else if (bus_receive_valid_i && cnt_r != 3'h7) begin
         cnt_r <= cnt_r + 3'h1;
         head_r <= (cnt_r < 3'h3) ? {head_r[15:0], bus_receive_byte_i} : head_r;
      end
   end
   // A well framed three byte frame to a fixed accepted address ends in this cycle.
   assign fok = bus_receive_end_i && cnt_r == 3'h3 && head_r[23:18] == 6'h38
      && (head_r[15:8] == 8'h10 || head_r[15:8] == 8'h00);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_head; bus_transmit_valid_o && !bus_transmit_last_o |->
      bus_transmit_byte_o == 8'he4 ##1 bus_transmit_valid_o && bus_transmit_last_o; endproperty
   a_head: assert property (p_head) else $error("reply head or pairing wrong");
   property p_idle; !bus_transmit_valid_o |->
      bus_transmit_byte_o == 8'h00 && !bus_transmit_last_o; endproperty
   a_idle: assert property (p_idle) else $error("idle reply lines not zero");
   property p_after_end; bus_transmit_valid_o && !bus_transmit_last_o |->
      $past(bus_receive_end_i); endproperty
   a_after_end: assert property (p_after_end) else $error("reply without a frame");
   property p_status; fok && head_r[7:0] == 8'h10 |=>
      bus_transmit_valid_o && bus_transmit_byte_o == 8'he4; endproperty
   a_status: assert property (p_status) else $error("status read not answered");
   property p_unknown; fok && head_r[7:0] == 8'h12 |=>
      !bus_transmit_valid_o [*3]; endproperty
   a_unknown: assert property (p_unknown) else $error("unknown command answered");
   property p_standby; fok && head_r[7:0] == 8'h02 |->
      ##2 standby_output_o; endproperty
   a_standby: assert property (p_standby) else $error("standby not asserted");
   property p_reset_cmd; fok && head_r[7:0] == 8'h00 |->
      ##2 legacy_mode_o && !standby_output_o; endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not obeyed");
   property p_legacy_fall; $fell(legacy_mode_o) |->
      $past(bus_receive_end_i, 2); endproperty
   a_legacy_fall: assert property (p_legacy_fall) else $error("legacy left without frame");
endmodule
bind lnbsci_top lnbsci_top_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .bus_receive_byte_i(bus_receive_byte_i), .bus_receive_valid_i(bus_receive_valid_i),
   .bus_receive_end_i(bus_receive_end_i), .bus_transmit_byte_o(bus_transmit_byte_o),
   .bus_transmit_valid_o(bus_transmit_valid_o), .bus_transmit_last_o(bus_transmit_last_o),
   .standby_output_o(standby_output_o), .legacy_mode_o(legacy_mode_o));

//--- bench/tb_lnb_slave_command_interpreter.sv
// Self-checking bench for the command interpreter against a behavioural model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_lnb_slave_command_interpreter;
   import lnbsci_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cen = 1'b1;
   logic sup = 1'b0, ton = 1'b0, bur = 1'b0;
   logic rx_v, rx_e, tx_v, stby, leg;
   lnbsci_byte_t rx_b, tx_b;
   logic [7:0] sw;
   lnbsci_byte_t live = 8'h14;
   lnbsci_byte_t p [5] = '{8'h14, 8'h00, 8'h0a, 8'h5a, 8'hff}; // Serial high is arbitrary.
   lnbsci_byte_t eq [$];
   lnbsci_byte_t rq [$];
   logic [3:0] cm = 4'h0, un = 4'h0;
   logic lk = 1'b0, ct = 1'b0, sb = 1'b0, lg = 1'b1, rf = 1'b1;
   int n_fail = 0, n_tests = 0, cyc = 0;
   logic [31:0] lf = 32'd72343;
   lnbsci_byte_t cl [16] = '{8'h10, 8'h01, 8'h10, 8'h04, 8'h05, 8'h07, 8'h08, 8'h10,
      8'h06, 8'h05, 8'h07, 8'h09, 8'h02, 8'h10, 8'h03, 8'h10};
   lnbsci_byte_t cf [5] = '{8'h00, 8'h20, 8'h0a, 8'h4a, 8'h82};
   lnbsci_master m (.core_clk_i(core_clk_i), .byte_o(rx_b), .valid_o(rx_v), .end_o(rx_e));
   lnbsci_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(cen),
      .bus_receive_byte_i(rx_b), .bus_receive_valid_i(rx_v), .bus_receive_end_i(rx_e),
      .supply_high_i(sup), .tone_present_i(ton), .burst_b_i(bur),
      .bus_transmit_byte_o(tx_b), .bus_transmit_valid_o(tx_v), .bus_transmit_last_o(),
      .switch_out_o(sw), .standby_output_o(stby), .legacy_mode_o(leg));
   // Clock of 100 ns period.
   initial forever #50 core_clk_i = ~core_clk_i;
   // Collects reply bytes and cuts a hung run short.
   always @(posedge core_clk_i) begin
      if (tx_v) rq.push_back(tx_b);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   // Next value of the pseudo-random sequence.
   function automatic lnbsci_byte_t rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   // Expected output pins for the given lines and configuration byte.
   function automatic logic [7:0] omap(logic [3:0] c, logic [3:0] u, lnbsci_byte_t g);
      logic [7:0] v = {u, c};
      int n = int'(g[4:1]);
      int s = v[(n + 7) % 8] + 2 * v[n % 8] + 4 * v[(n + 1) % 8];
      if (n != 0) return 8'h01 << (g[6] ? s % 4 : s);
      return g[5] ? {~c, c} : v;
   endfunction
   // Compares pins and replies with the model.
   task automatic expect_pins();
      logic [3:0] c = p[2][0] ? {1'b0, ton, sup, 1'b0} : {1'b0, bur, sup, ton};
      `CHK("switch", omap(lg ? c : cm, lg ? 4'h0 : un, p[2]), sw)
      `CHK("standby", sb, stby)
      `CHK("legacy", lg, leg)
      `CHK("replies", eq.size(), rq.size())
      for (int i = 0; i < eq.size() && i < rq.size(); i++) `CHK("reply", eq[i], rq[i])
      eq = {};
      rq = {};
   endtask
   // Sends one frame, steps the model and checks the outcome.
   task automatic frame(input lnbsci_byte_t a, c, d0, d1, input int n);
      int need = (c inside {8'h08, 8'h09, 8'h38, 8'h39, 8'h0d}) ? 1 : (c == 8'h0f) ? 2 : 0;
      m.send(a, c, d0, d1, n);
      if ((a == live || a == 8'h10 || a == 8'h00) && n == need && (c != 8'h0d || d0 < 8'h05)
         && c inside {[8'h00:8'h09], 8'h0d, 8'h0f, 8'h10, 8'h11, 8'h14, 8'h15,
         [8'h20:8'h2f], 8'h38, 8'h39, [8'h51:8'h53]}) begin
         lg = 1'b0;
         case (c)
            8'h00: begin
               {lg, rf, sb, ct, cm, un} = {4'b1100, 8'h00};
               live = p[0];
            end
            8'h01: rf = 1'b0;
            8'h02, 8'h03: sb = ~c[0];
            8'h04, 8'h06: ct = ~c[1];
            8'h05, 8'h07: if (ct ^ c[1]) eq = '{8'he4, live};
            8'h08, 8'h09: if (ct ^ c[0]) live = d0;
            8'h10: eq = '{8'he4, {3'h0, lk, ct, lg, sb, rf}};
            8'h11: eq = '{8'he4, p[2]};
            8'h14: eq = '{8'he4, {4'h0, cm}};
            8'h15: eq = '{8'he4, {4'h0, un}};
            8'h38: cm = d0[3:0];
            8'h39: un = d0[3:0];
            8'h51: eq = '{8'he4, {4'h0, cm[0] ? p[1][7:4] : p[1][3:0]}};
            8'h52: eq = '{8'he4, {4'h0, p[1][3:0]}};
            8'h53: eq = '{8'he4, {4'h0, p[1][7:4]}};
            8'h0d: eq = '{8'he4, p[d0]};
            8'h0f: if (d0 == 8'hff && d1 == 8'hff) lk = 1'b1;
               else if (!lk && d0 < 8'h05) begin
                  p[d0] = (d0 == 8'h02) ? d1 & 8'h7f : d1;
                  if (d0 == 8'h00) live = d1;
               end
            default: if (c[3]) un[c[1:0]] = c[2]; else cm[c[1:0]] = c[2];
         endcase
      end
      repeat (6) @(posedge core_clk_i);
      expect_pins();
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reset, defaults, command sweep, legacy signalling, output modes, refusals, freeze, lock.
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      expect_pins();
      for (int i = 0; i < 6; i++) frame(8'h10, 8'h0d, i[7:0], 8'h00, 1);
      foreach (cl[i]) frame(8'h10, cl[i], rnd(), 8'h00, int'(cl[i] inside {8'h08, 8'h09}));
      for (int k = 8'h20; k < 8'h30; k++) begin
         frame(8'h10, k[7:0], 8'h00, 8'h00, 0);
         frame(8'h10, 8'h14, 8'h00, 8'h00, 0);
         frame(8'h10, 8'h15, 8'h00, 8'h00, 0);
      end
      for (int g = 0; g < 2; g++) begin
         frame(8'h00, 8'h0f, 8'h02, g[7:0], 2);
         frame(8'h10, 8'h0f, 8'h00, 8'h2b + g[7:0], 2);
         frame(8'h00, 8'h00, 8'h00, 8'h00, 0);
         repeat (4) begin
            void'(rnd());
            {sup, ton, bur} <= lf[2:0];
            repeat (8) @(posedge core_clk_i);
            expect_pins();
         end
         {sup, ton, bur} <= 3'h0;
         repeat (8) @(posedge core_clk_i);
         frame(8'h10, 8'h01, 8'h00, 8'h00, 0);
         frame(8'h2b + g[7:0], 8'h10, 8'h00, 8'h00, 0);
      end
      foreach (cf[i]) begin
         frame(8'h10, 8'h0f, 8'h02, cf[i], 2);
         frame(8'h10, 8'h11, 8'h00, 8'h00, 0);
         frame(8'h10, 8'h0f, 8'h01, rnd(), 2);
         repeat (3) begin
            frame(8'h10, 8'h38, rnd(), 8'h00, 1);
            frame(8'h10, 8'h39, rnd(), 8'h00, 1);
            for (int k = 8'h51; k < 8'h54; k++) frame(8'h10, k[7:0], 8'h00, 8'h00, 0);
         end
      end
      frame(8'h5b, 8'h02, 8'h00, 8'h00, 0);
      frame(8'h10, 8'h12, 8'h00, 8'h00, 0);
      frame(8'h10, 8'h10, rnd(), 8'h00, 1);
      cen <= 1'b0;
      m.send(8'h10, 8'h38, {4'h0, ~cm}, 8'h00, 1);
      repeat (6) @(posedge core_clk_i);
      expect_pins();
      cen <= 1'b1;
      frame(8'h10, 8'h0f, 8'hff, 8'hff, 2);
      frame(8'h10, 8'h0f, 8'h02, 8'h20, 2);
      frame(8'h10, 8'h11, 8'h00, 8'h00, 0);
      frame(8'h10, 8'h10, 8'h00, 8'h00, 0);
      close_out();
   end
endmodule

//--- rtl/lnbsci_map.svh
// Constants of the dish control bus slave command interpreter.
`ifndef LNBSCI_MAP_SVH
`define LNBSCI_MAP_SVH
`define LNBSCI_CMD_RESET 8'h00
`define LNBSCI_CMD_CLR_RESET 8'h01
`define LNBSCI_CMD_STANDBY 8'h02
`define LNBSCI_CMD_POWER_ON 8'h03
`define LNBSCI_CMD_SET_CONT 8'h04
`define LNBSCI_CMD_CONTEND 8'h05
`define LNBSCI_CMD_CLR_CONT 8'h06
`define LNBSCI_CMD_ADDRESS 8'h07
`define LNBSCI_CMD_MOVE_C 8'h08
`define LNBSCI_CMD_MOVE 8'h09
`define LNBSCI_CMD_PARAM_READ 8'h0d
`define LNBSCI_CMD_PARAM_WRITE 8'h0f
`define LNBSCI_CMD_STATUS 8'h10
`define LNBSCI_CMD_CONFIG 8'h11
`define LNBSCI_CMD_GROUP0 8'h14
`define LNBSCI_CMD_GROUP1 8'h15
`define LNBSCI_CMD_COMMIT_HI5 5'h04
`define LNBSCI_CMD_UNCOMMIT_HI5 5'h05
`define LNBSCI_CMD_WRITE_COMMITTED_GROUP 8'h38
`define LNBSCI_CMD_WRITE_UNCOMMITTED_GROUP 8'h39
`define LNBSCI_CMD_LO_CUR 8'h51
`define LNBSCI_CMD_LO_LOW 8'h52
`define LNBSCI_CMD_LO_HIGH 8'h53
`define LNBSCI_FRAME_HI6 6'h38
`define LNBSCI_REPLY_HEAD 8'he4
`define LNBSCI_ADDR_ALT_A 8'h10
`define LNBSCI_ADDR_ALT_B 8'h00
`define LNBSCI_LOCK_KEY 8'hff
`define LNBSCI_LEN_SHORT 3'h3
`define LNBSCI_LEN_DATA 3'h4
`define LNBSCI_LEN_PARAM 3'h5
`define LNBSCI_NPARAM 5
`define LNBSCI_IDX_ADDR 3'h0
`define LNBSCI_IDX_LO 3'h1
`define LNBSCI_IDX_CFG 3'h2
`define LNBSCI_IDX_SER_HI 3'h3
`define LNBSCI_IDX_SER_LO 3'h4
`define LNBSCI_RST_ADDR 8'h14
`define LNBSCI_RST_LO 8'h00
`define LNBSCI_RST_CFG 8'h0a
`define LNBSCI_RST_SER_LO 8'hff
`define LNBSCI_CFG_MASK 8'h7f
`define LNBSCI_CFG_TONE_BIT 0
`define LNBSCI_CFG_COMP_BIT 5
`define LNBSCI_CFG_TWO_BIT 6
`define LNBSCI_ST_RESET_BIT 0
`define LNBSCI_ST_STANDBY_BIT 1
`define LNBSCI_ST_LEGACY_BIT 2
`define LNBSCI_ST_CONT_BIT 3
`define LNBSCI_ST_LOCK_BIT 4
`endif

//--- rtl/lnbsci_outmap.sv
// Output mode mapping of the eight switching lines onto the output pins.
`timescale 1ns/1ps
`include "lnbsci_map.svh"
module lnbsci_outmap
   import lnbsci_pkg::*;
(
   input wire logic [3:0] comm_i,
   input wire logic [3:0] uncom_i,
   input wire lnbsci_byte_t cfg_i,
   output logic [7:0] op_o
);
   // Line order: band, polarization, position, option, switches one to four.
   wire [7:0] lines_w = {uncom_i, comm_i};
   wire [3:0] mode_w = cfg_i[4:1];
   wire dec_on_w = (mode_w != 4'h0);
   wire comp_on_w = cfg_i[`LNBSCI_CFG_COMP_BIT];
   wire two_on_w = cfg_i[`LNBSCI_CFG_TWO_BIT];
   wire [2:0] base_w = mode_w[2:0] - 3'h1;
   logic [2:0] sel_w;
   // Pick three adjacent lines starting at the mode's line, wrapping round.
   generate
      for (genvar k = 0; k < 3; k++) begin : g_sel
         assign sel_w[k] = lines_w[base_w + 3'(k)];
      end
   endgenerate
   wire [7:0] dec8_w = 8'h01 << sel_w;
   wire [7:0] dec4_w = 8'h01 << sel_w[1:0];
   wire [7:0] dec_w = two_on_w ? dec4_w : dec8_w;
   // Decoded mode wins over complementary, which wins over single polarity.
   assign op_o = dec_on_w ? dec_w :
                 comp_on_w ? {~comm_i, comm_i} :
                 lines_w;
endmodule

//--- rtl/lnbsci_pkg.sv
// Types shared by the command interpreter modules.
package lnbsci_pkg;
   // Reply sender states, one-hot.
   typedef enum logic [2:0] {
      LNBSCI_TX_IDLE = 3'b001,
      LNBSCI_TX_HEAD = 3'b010,
      LNBSCI_TX_DATA = 3'b100
   } lnbsci_tx_t;
   typedef logic [7:0] lnbsci_byte_t;
endpackage

//--- rtl/lnbsci_top.sv
// Command interpreter for the slave side of a dish control bus.
`timescale 1ns/1ps
`include "lnbsci_map.svh"
module lnbsci_top
   import lnbsci_pkg::*;
#(
   parameter lnbsci_byte_t SER_HI_RESET = 8'h5a // Arbitrary serial value.
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire lnbsci_byte_t bus_receive_byte_i,
   input wire logic bus_receive_valid_i,
   input wire logic bus_receive_end_i,
   input wire logic supply_high_i,
   input wire logic tone_present_i,
   input wire logic burst_b_i,
   output lnbsci_byte_t bus_transmit_byte_o,
   output logic bus_transmit_valid_o,
   output logic bus_transmit_last_o,
   output logic [7:0] switch_out_o,
   output logic standby_output_o,
   output logic legacy_mode_o
);

   // Frame capture storage.
   lnbsci_byte_t frm_r [0:4];
   logic [2:0] cnt_r;
   logic over_r;

   // Interpreter state.
   lnbsci_byte_t addr_r;
   lnbsci_byte_t par_r [0:`LNBSCI_NPARAM-1];
   logic lock_r;
   logic cont_r;
   logic rstflag_r;
   logic standby_r;
   logic legacy_r;
   logic [3:0] comm_r;
   logic [3:0] uncom_r;

   // Reply sender.
   lnbsci_tx_t tx_r;
   lnbsci_tx_t tx_nxt;
   lnbsci_byte_t rep_r;
   lnbsci_byte_t txb_r;
   logic txv_r;
   logic txl_r;

   // Output stage.
   logic [7:0] op_r;
   logic sby_r;
   logic leg_r;

   // Pin synchronisers for supply level, tone and burst.
   wire [2:0] pin_w = {burst_b_i, tone_present_i, supply_high_i};
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] lvl_r;

   // True when a command code lies in an eight-code block.
   function automatic logic in_block(input lnbsci_byte_t c, input logic [4:0] hi);
      in_block = (c[7:3] == hi);
   endfunction

   // Three stages and a level flop per pin; the level moves once stages two and three agree.
   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1_r[i] <= 1'b0;
               s2_r[i] <= 1'b0;
               s3_r[i] <= 1'b0;
               lvl_r[i] <= 1'b0;
            end else if (clk_en_i) begin
               s1_r[i] <= pin_w[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  lvl_r[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate

   // Named fields of the captured frame.
   wire [7:0] hdr_w = frm_r[0];
   wire [7:0] adr_w = frm_r[1];
   wire [7:0] cmd_w = frm_r[2];
   wire [7:0] d3_w = frm_r[3];
   wire [7:0] d4_w = frm_r[4];
   wire len3_w = (cnt_r == `LNBSCI_LEN_SHORT);
   wire len4_w = (cnt_r == `LNBSCI_LEN_DATA);
   wire len5_w = (cnt_r == `LNBSCI_LEN_PARAM);

   // Frame acceptance: command framing byte and an accepted address.
   wire hdr_ok_w = (hdr_w[7:2] == `LNBSCI_FRAME_HI6);
   wire adr_ok_w = (adr_w == addr_r) ||
                   (adr_w == `LNBSCI_ADDR_ALT_A) ||
                   (adr_w == `LNBSCI_ADDR_ALT_B);
   wire frame_ok_w = bus_receive_end_i && !over_r && hdr_ok_w && adr_ok_w;

   // Command recognition, each by its frame length.
   wire c_reset_w = (cmd_w == `LNBSCI_CMD_RESET) && len3_w;
   wire c_clr_w = (cmd_w == `LNBSCI_CMD_CLR_RESET) && len3_w;
   wire c_sby_w = (cmd_w == `LNBSCI_CMD_STANDBY) && len3_w;
   wire c_pon_w = (cmd_w == `LNBSCI_CMD_POWER_ON) && len3_w;
   wire c_scont_w = (cmd_w == `LNBSCI_CMD_SET_CONT) && len3_w;
   wire c_contend_w = (cmd_w == `LNBSCI_CMD_CONTEND) && len3_w;
   wire c_ccont_w = (cmd_w == `LNBSCI_CMD_CLR_CONT) && len3_w;
   wire c_addr_w = (cmd_w == `LNBSCI_CMD_ADDRESS) && len3_w;
   wire c_movec_w = (cmd_w == `LNBSCI_CMD_MOVE_C) && len4_w;
   wire c_move_w = (cmd_w == `LNBSCI_CMD_MOVE) && len4_w;
   wire c_stat_w = (cmd_w == `LNBSCI_CMD_STATUS) && len3_w;
   wire c_cfg_w = (cmd_w == `LNBSCI_CMD_CONFIG) && len3_w;
   wire c_g0_w = (cmd_w == `LNBSCI_CMD_GROUP0) && len3_w;
   wire c_g1_w = (cmd_w == `LNBSCI_CMD_GROUP1) && len3_w;
   wire c_cset_w = in_block(cmd_w, `LNBSCI_CMD_COMMIT_HI5) && len3_w;
   wire c_uset_w = in_block(cmd_w, `LNBSCI_CMD_UNCOMMIT_HI5) && len3_w;
   wire c_wn0_w = (cmd_w == `LNBSCI_CMD_WRITE_COMMITTED_GROUP) && len4_w;
   wire c_wn1_w = (cmd_w == `LNBSCI_CMD_WRITE_UNCOMMITTED_GROUP) && len4_w;
   wire c_locur_w = (cmd_w == `LNBSCI_CMD_LO_CUR) && len3_w;
   wire c_lolo_w = (cmd_w == `LNBSCI_CMD_LO_LOW) && len3_w;
   wire c_lohi_w = (cmd_w == `LNBSCI_CMD_LO_HIGH) && len3_w;
   wire c_prd_w = (cmd_w == `LNBSCI_CMD_PARAM_READ) && len4_w &&
                  (d3_w < 8'(`LNBSCI_NPARAM));
   wire c_pwr_w = (cmd_w == `LNBSCI_CMD_PARAM_WRITE) && len5_w;

   // Anything outside this set is ignored with no effect at all.
   wire known_w = c_reset_w || c_clr_w || c_sby_w || c_pon_w ||
                  c_scont_w || c_contend_w || c_ccont_w || c_addr_w ||
                  c_movec_w || c_move_w || c_stat_w || c_cfg_w ||
                  c_g0_w || c_g1_w || c_cset_w || c_uset_w ||
                  c_wn0_w || c_wn1_w || c_locur_w || c_lolo_w ||
                  c_lohi_w || c_prd_w || c_pwr_w;
   wire exec_w = frame_ok_w && known_w;
   wire ex_w = exec_w && !c_reset_w;

   // Parameter write decode: lock key, refusal once locked, index range.
   wire key_w = (d3_w == `LNBSCI_LOCK_KEY) && (d4_w == `LNBSCI_LOCK_KEY);
   wire pw_lock_w = exec_w && c_pwr_w && key_w && !lock_r;
   wire pw_ok_w = exec_w && c_pwr_w && !key_w && !lock_r &&
                  (d3_w < 8'(`LNBSCI_NPARAM));
   wire [2:0] pidx_w = d3_w[2:0];
   wire pw_addr_w = pw_ok_w && (pidx_w == `LNBSCI_IDX_ADDR);

   // Address moves guarded by the contention flag.
   wire move_w = exec_w && ((c_movec_w && cont_r) || (c_move_w && !cont_r));

   // Effective committed lines: legacy inputs until the first executed command other than reset.
   wire tone_pos_w = par_r[`LNBSCI_IDX_CFG][`LNBSCI_CFG_TONE_BIT];
   wire [3:0] leg_w = {1'b0,
                       tone_pos_w ? lvl_r[1] : lvl_r[2],
                       lvl_r[0],
                       tone_pos_w ? 1'b0 : lvl_r[1]};
   wire [3:0] comm_eff_w = legacy_r ? leg_w : comm_r;

   // Oscillator entry numbers, high nibble high band, low nibble low band.
   wire [3:0] lo_hi_w = par_r[`LNBSCI_IDX_LO][7:4];
   wire [3:0] lo_lo_w = par_r[`LNBSCI_IDX_LO][3:0];
   wire [3:0] lo_cur_w = comm_eff_w[0] ? lo_hi_w : lo_lo_w;

   // Status byte seen by the status read.
   wire [7:0] stat_w = {3'h0, lock_r, cont_r, legacy_r, standby_r, rstflag_r};

   // Which frames ask for a reply, and the data byte it carries.
   wire rep_req_w = exec_w && ((c_contend_w && cont_r) ||
                               (c_addr_w && !cont_r) ||
                               c_stat_w || c_cfg_w || c_g0_w || c_g1_w ||
                               c_locur_w || c_lolo_w || c_lohi_w || c_prd_w);
   wire [7:0] rep_w = (c_contend_w || c_addr_w) ? addr_r :
                      c_stat_w ? stat_w :
                      c_cfg_w ? par_r[`LNBSCI_IDX_CFG] :
                      c_g0_w ? {4'h0, comm_eff_w} :
                      c_g1_w ? {4'h0, uncom_r} :
                      c_locur_w ? {4'h0, lo_cur_w} :
                      c_lolo_w ? {4'h0, lo_lo_w} :
                      c_lohi_w ? {4'h0, lo_hi_w} :
                      par_r[pidx_w];

   // Collect up to five bytes; a longer frame is marked and dropped.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 3'h0;
         over_r <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            frm_r[i] <= 8'h00;
         end
      end else if (clk_en_i) begin
         if (bus_receive_end_i) begin
            cnt_r <= 3'h0;
            over_r <= 1'b0;
         end else if (bus_receive_valid_i) begin
            if (cnt_r == `LNBSCI_LEN_PARAM) begin
               over_r <= 1'b1;
            end else begin
               frm_r[cnt_r] <= bus_receive_byte_i;
               cnt_r <= cnt_r + 3'h1;
            end
         end
      end
   end

   // Flags, standby and the legacy mode latch.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         legacy_r <= 1'b1;
         rstflag_r <= 1'b1;
         standby_r <= 1'b0;
         cont_r <= 1'b0;
      end else if (clk_en_i && exec_w) begin
         legacy_r <= c_reset_w;
         if (c_reset_w) begin
            rstflag_r <= 1'b1;
            standby_r <= 1'b0;
            cont_r <= 1'b0;
         end else if (c_clr_w) begin
            rstflag_r <= 1'b0;
         end else if (c_sby_w) begin
            standby_r <= 1'b1;
         end else if (c_pon_w) begin
            standby_r <= 1'b0;
         end else if (c_scont_w) begin
            cont_r <= 1'b1;
         end else if (c_ccont_w) begin
            cont_r <= 1'b0;
         end
      end
   end

   // Committed and uncommitted switching lines.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         comm_r <= 4'h0;
         uncom_r <= 4'h0;
      end else if (clk_en_i) begin
         if (exec_w && c_reset_w) begin
            comm_r <= 4'h0;
            uncom_r <= 4'h0;
         end else if (ex_w && c_cset_w) begin
            comm_r[cmd_w[1:0]] <= cmd_w[2];
         end else if (ex_w && c_uset_w) begin
            uncom_r[cmd_w[1:0]] <= cmd_w[2];
         end else if (ex_w && c_wn0_w) begin
            comm_r <= d3_w[3:0];
         end else if (ex_w && c_wn1_w) begin
            uncom_r <= d3_w[3:0];
         end
      end
   end

   // Nonvolatile parameters, the lock and the live address.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         par_r[`LNBSCI_IDX_ADDR] <= `LNBSCI_RST_ADDR;
         par_r[`LNBSCI_IDX_LO] <= `LNBSCI_RST_LO;
         par_r[`LNBSCI_IDX_CFG] <= `LNBSCI_RST_CFG;
         par_r[`LNBSCI_IDX_SER_HI] <= SER_HI_RESET;
         par_r[`LNBSCI_IDX_SER_LO] <= `LNBSCI_RST_SER_LO;
         lock_r <= 1'b0;
         addr_r <= `LNBSCI_RST_ADDR;
      end else if (clk_en_i) begin
         if (pw_lock_w) begin
            lock_r <= 1'b1;
         end
         if (pw_ok_w && (pidx_w == `LNBSCI_IDX_CFG)) begin
            par_r[pidx_w] <= d4_w & `LNBSCI_CFG_MASK;
         end else if (pw_ok_w) begin
            par_r[pidx_w] <= d4_w;
         end
         if (pw_addr_w) begin
            addr_r <= d4_w;
         end else if (exec_w && c_reset_w) begin
            addr_r <= par_r[`LNBSCI_IDX_ADDR];
         end else if (move_w) begin
            addr_r <= d3_w;
         end
      end
   end

   // Reply sender: head byte then data byte, one per cycle.
   always_comb begin
      tx_nxt = tx_r;
      case (tx_r)
         LNBSCI_TX_IDLE: begin
            if (rep_req_w) begin
               tx_nxt = LNBSCI_TX_HEAD;
            end
         end
         LNBSCI_TX_HEAD: begin
            tx_nxt = LNBSCI_TX_DATA;
         end
         LNBSCI_TX_DATA: begin
            tx_nxt = LNBSCI_TX_IDLE;
         end
         default: begin
            tx_nxt = LNBSCI_TX_IDLE;
         end
      endcase
   end

   // Reply state and registered transmit strobes.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_r <= LNBSCI_TX_IDLE;
         rep_r <= 8'h00;
         txb_r <= 8'h00;
         txv_r <= 1'b0;
         txl_r <= 1'b0;
      end else if (clk_en_i) begin
         tx_r <= tx_nxt;
         if (rep_req_w && (tx_r == LNBSCI_TX_IDLE)) begin
            rep_r <= rep_w;
         end
         txv_r <= (tx_nxt != LNBSCI_TX_IDLE);
         txl_r <= (tx_nxt == LNBSCI_TX_DATA);
         if (tx_nxt == LNBSCI_TX_HEAD) begin
            txb_r <= `LNBSCI_REPLY_HEAD;
         end else if (tx_nxt == LNBSCI_TX_DATA) begin
            txb_r <= rep_r;
         end else begin
            txb_r <= 8'h00;
         end
      end
   end

   // Output mode mapping of the effective lines.
   logic [7:0] op_w;
   lnbsci_outmap u_outmap (
      .comm_i(comm_eff_w),
      .uncom_i(uncom_r),
      .cfg_i(par_r[`LNBSCI_IDX_CFG]),
      .op_o(op_w)
   );

   // Registered pin drivers.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_r <= 8'h00;
         sby_r <= 1'b0;
         leg_r <= 1'b1;
      end else if (clk_en_i) begin
         op_r <= op_w;
         sby_r <= standby_r;
         leg_r <= legacy_r;
      end
   end

   assign bus_transmit_byte_o = txb_r;
   assign bus_transmit_valid_o = txv_r;
   assign bus_transmit_last_o = txl_r;
   assign switch_out_o = op_r;
   assign standby_output_o = sby_r;
   assign legacy_mode_o = leg_r;

endmodule
